//--- logic/usrd_defines.vh
`ifndef USRD_DEFINES_VH
`define USRD_DEFINES_VH

// Register byte offsets
`define USRD_CTRL_OFFSET      8'h00
`define USRD_STATUS_OFFSET    8'h04

// Control register field positions
`define USRD_XCVR_LSB         0
`define USRD_XCVR_MSB         1
`define USRD_TERM_BIT         2
`define USRD_OPERATING_MODE_LSB       3
`define USRD_OPERATING_MODE_MSB       4
`define USRD_DP_PD_BIT        5
`define USRD_DM_PD_BIT        6

// Status register field positions
`define USRD_ST_PULLUP_BIT    0
`define USRD_ST_DP_PD_BIT     1
`define USRD_ST_DM_PD_BIT     2
`define USRD_ST_HSTERM_BIT    3

// Field reset values: power-up state with both pull-downs on
`define USRD_XCVR_RESET       2'h1
`define USRD_TERM_RESET       1'h0
`define USRD_OPERATING_MODE_RESET     2'h0
`define USRD_DP_PD_RESET      1'h1
`define USRD_DM_PD_RESET      1'h1

// Enable reset values match the decode of the reset fields
`define USRD_PULLUP_RESET     1'h0
`define USRD_DP_PD_EN_RESET   1'h1
`define USRD_DM_PD_EN_RESET   1'h1
`define USRD_HSTERM_RESET     1'h0

// Operating mode that releases every bus resistor
`define USRD_OPERATING_MODE_DISABLED  2'h1
// Transceiver select for high-speed
`define USRD_XCVR_HS          2'h0

// AXI responses
`define USRD_RESP_OKAY        2'h0
`define USRD_RESP_SLVERR      2'h2
`define USRD_RESP_DECERR      2'h3

`endif

//--- logic/usrd_resistor_map.v
`timescale 1ns/1ns
`include "usrd_defines.vh"

module usrd_resistor_map (
	// State fields
	input  wire [1:0] transceiver_speed_select,
	input  wire       termination_select,
	input  wire [1:0] operating_mode,
	input  wire       dplus_pulldown_select,
	input  wire       dminus_pulldown_select,
	// Resistor enables
	output wire       dplus_pullup_enable,
	output wire       dplus_pulldown_enable,
	output wire       dminus_pulldown_enable,
	output wire       highspeed_termination_enable
);

	wire all_off;

	assign all_off = (operating_mode == `USRD_OPERATING_MODE_DISABLED);

	assign dplus_pullup_enable = !all_off && termination_select
		&& !dplus_pulldown_select;
	assign dplus_pulldown_enable = !all_off
		&& dplus_pulldown_select;
	assign dminus_pulldown_enable = !all_off
		&& dminus_pulldown_select;
	// Test J/K states fall out of the same terms
	assign highspeed_termination_enable = !all_off
		&& (transceiver_speed_select == `USRD_XCVR_HS)
		&& !termination_select;

endmodule // usrd_resistor_map

//--- logic/usrd_state_decode.v
// What this block does
// - The bus electrical state comes only from the transceiver select, termination select, operating mode and the two pull-down select fields.
// - Those five fields alone force the four resistor enables; nothing else can set them.
// - Operating mode 01b turns all four resistor enables off regardless of the other fields.
// - The DP pull-up is on only with termination select 1, DP pull-down select 0 and mode not 01b.
// - The DP pull-down enable follows the DP pull-down select except in mode 01b.
// - The DM pull-down enable follows the DM pull-down select except in mode 01b.
// - High-speed termination is on only with transceiver select 00b, termination select 0 and mode not 01b.
// - Host test J/K (00b, 0, 10b, 1, 1) gives both pull-downs and termination with the pull-up off.
// - Peripheral test J/K (00b, 0, 10b, 0, 0) gives termination only.
`timescale 1ns/1ns
`include "usrd_defines.vh"

module usrd_state_decode (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Bus resistor enables
	output reg         dplus_pullup_enable,
	output reg         dplus_pulldown_enable,
	output reg         dminus_pulldown_enable,
	output reg         highspeed_termination_enable
);

	// Stored state fields
	reg  [1:0]  transceiver_speed_select;
	reg         termination_select;
	reg  [1:0]  operating_mode;
	reg         dplus_pulldown_select;
	reg         dminus_pulldown_select;

	// Write channel capture
	reg         aw_held;
	reg  [7:0]  aw_addr;
	reg         w_held;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;

	wire        do_write;
	wire        ctrl_hit;
	wire        ctrl_write;

	// Captured word slices
	wire [1:0]  wr_xcvr;
	wire        wr_term;
	wire [1:0]  wr_operating_mode;
	wire        wr_dp_pd;
	wire        wr_dm_pd;

	// Next state and decode
	reg  [1:0]  next_xcvr;
	reg         next_term;
	reg  [1:0]  next_operating_mode;
	reg         next_dp_pd;
	reg         next_dm_pd;
	wire        next_pullup;
	wire        next_dp_pd_en;
	wire        next_dm_pd_en;
	wire        next_hsterm;

	// Bus answers
	reg  [1:0]  write_resp;
	reg  [31:0] ctrl_word;
	reg  [31:0] status_word;
	reg  [31:0] read_word;
	reg  [1:0]  read_resp;

	// A write waits here while its response is still pending
	assign do_write   = aw_held && w_held && !s_axi_bvalid;
	assign ctrl_hit   = (aw_addr == `USRD_CTRL_OFFSET);
	// Only the low byte holds fields; other lanes are ignored
	assign ctrl_write = do_write && ctrl_hit && w_strb[0];

	// Field slices of the captured word
	assign wr_xcvr   = w_data[`USRD_XCVR_MSB:`USRD_XCVR_LSB];
	assign wr_term   = w_data[`USRD_TERM_BIT];
	assign wr_operating_mode = w_data[`USRD_OPERATING_MODE_MSB:`USRD_OPERATING_MODE_LSB];
	assign wr_dp_pd  = w_data[`USRD_DP_PD_BIT];
	assign wr_dm_pd  = w_data[`USRD_DM_PD_BIT];

	always @* begin
		next_xcvr   = transceiver_speed_select;
		next_term   = termination_select;
		next_operating_mode = operating_mode;
		next_dp_pd  = dplus_pulldown_select;
		next_dm_pd  = dminus_pulldown_select;
		if (ctrl_write) begin
			next_xcvr   = wr_xcvr;
			next_term   = wr_term;
			next_operating_mode = wr_operating_mode;
			next_dp_pd  = wr_dp_pd;
			next_dm_pd  = wr_dm_pd;
		end
	end

	// Decode from the next field values so enables move with the fields
	usrd_resistor_map u_map (
		.transceiver_speed_select     (next_xcvr),
		.termination_select           (next_term),
		.operating_mode               (next_operating_mode),
		.dplus_pulldown_select        (next_dp_pd),
		.dminus_pulldown_select       (next_dm_pd),
		.dplus_pullup_enable          (next_pullup),
		.dplus_pulldown_enable        (next_dp_pd_en),
		.dminus_pulldown_enable       (next_dm_pd_en),
		.highspeed_termination_enable (next_hsterm)
	);

	// Stored fields
	always @(posedge aclk) begin
		if (!aresetn) begin
			transceiver_speed_select <= `USRD_XCVR_RESET;
			termination_select       <= `USRD_TERM_RESET;
			operating_mode           <= `USRD_OPERATING_MODE_RESET;
			dplus_pulldown_select    <= `USRD_DP_PD_RESET;
			dminus_pulldown_select   <= `USRD_DM_PD_RESET;
		end else begin
			transceiver_speed_select <= next_xcvr;
			termination_select       <= next_term;
			operating_mode           <= next_operating_mode;
			dplus_pulldown_select    <= next_dp_pd;
			dminus_pulldown_select   <= next_dm_pd;
		end
	end

	// Enables from flops so decode glitches never reach the pins
	always @(posedge aclk) begin
		if (!aresetn) begin
			dplus_pullup_enable          <= `USRD_PULLUP_RESET;
			dplus_pulldown_enable        <= `USRD_DP_PD_EN_RESET;
			dminus_pulldown_enable       <= `USRD_DM_PD_EN_RESET;
			highspeed_termination_enable <= `USRD_HSTERM_RESET;
		end else begin
			dplus_pullup_enable          <= next_pullup;
			dplus_pulldown_enable        <= next_dp_pd_en;
			dminus_pulldown_enable       <= next_dm_pd_en;
			highspeed_termination_enable <= next_hsterm;
		end
	end

	// Write address capture
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	// Address ready returns only once the response has gone
	always @(posedge aclk) begin
		if (!aresetn)
			s_axi_awready <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready)
			s_axi_awready <= 1'b0;
		else if (!aw_held && !s_axi_bvalid)
			s_axi_awready <= 1'b1;
	end

	// Write data capture, independent of the address order
	always @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// Data ready returns only once the response has gone
	always @(posedge aclk) begin
		if (!aresetn)
			s_axi_wready <= 1'b0;
		else if (s_axi_wvalid && s_axi_wready)
			s_axi_wready <= 1'b0;
		else if (!w_held && !s_axi_bvalid)
			s_axi_wready <= 1'b1;
	end

	// Write answer by address
	always @* begin
		case (aw_addr)
			`USRD_CTRL_OFFSET:   write_resp = `USRD_RESP_OKAY;
			`USRD_STATUS_OFFSET: write_resp = `USRD_RESP_SLVERR;
			default:             write_resp = `USRD_RESP_DECERR;
		endcase
	end

	// Response valid, held until taken
	always @(posedge aclk) begin
		if (!aresetn)
			s_axi_bvalid <= 1'b0;
		else if (do_write)
			s_axi_bvalid <= 1'b1;
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Response code, loaded with the valid
	always @(posedge aclk) begin
		if (!aresetn)
			s_axi_bresp <= `USRD_RESP_OKAY;
		else if (do_write)
			s_axi_bresp <= write_resp;
	end

	// Control word image; unused bits read as zero
	always @* begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[`USRD_XCVR_MSB:`USRD_XCVR_LSB] = transceiver_speed_select;
		ctrl_word[`USRD_TERM_BIT] = termination_select;
		ctrl_word[`USRD_OPERATING_MODE_MSB:`USRD_OPERATING_MODE_LSB] = operating_mode;
		ctrl_word[`USRD_DP_PD_BIT] = dplus_pulldown_select;
		ctrl_word[`USRD_DM_PD_BIT] = dminus_pulldown_select;
	end

	// Status word image of the enable pins
	always @* begin
		status_word = 32'h0000_0000;
		status_word[`USRD_ST_PULLUP_BIT] = dplus_pullup_enable;
		status_word[`USRD_ST_DP_PD_BIT]  = dplus_pulldown_enable;
		status_word[`USRD_ST_DM_PD_BIT]  = dminus_pulldown_enable;
		status_word[`USRD_ST_HSTERM_BIT] = highspeed_termination_enable;
	end

	// Read mux: unmapped addresses answer with zero data
	always @* begin
		read_word = 32'h0000_0000;
		read_resp = `USRD_RESP_OKAY;
		case (s_axi_araddr)
			`USRD_CTRL_OFFSET:   read_word = ctrl_word;
			`USRD_STATUS_OFFSET: read_word = status_word;
			default:             read_resp = `USRD_RESP_DECERR;
		endcase
	end

	// Read address ready: one read in flight at most
	always @(posedge aclk) begin
		if (!aresetn)
			s_axi_arready <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			s_axi_arready <= 1'b0;
		else if (!s_axi_rvalid || s_axi_rready)
			s_axi_arready <= 1'b1;
	end

	// Read valid, raised on the same edge that the address is taken
	always @(posedge aclk) begin
		if (!aresetn)
			s_axi_rvalid <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			s_axi_rvalid <= 1'b1;
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Read data and code, held until taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `USRD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rdata <= read_word;
			s_axi_rresp <= read_resp;
		end
	end

endmodule // usrd_state_decode

//--- tb/test_usrd_state_decode.sv
`timescale 1ns/1ns
module test_usrd_state_decode;
	logic        aclk = 1'b0;
	logic        aresetn;
	logic [2:0]  s_axi_awprot = 3'h0;
	logic [2:0]  s_axi_arprot = 3'h0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        dplus_pullup_enable, dplus_pulldown_enable;
	logic        dminus_pulldown_enable, highspeed_termination_enable;
	int          n_errors, checks;
	// Enables in [15:12], control fields in [6:0]
	logic [15:0] rows [16] = '{16'h0068, 16'h000D, 16'h6061, 16'h7070,
		16'h7060, 16'h6067, 16'h6075, 16'h6066, 16'h8014, 16'h1000,
		16'h8005, 16'h8015, 16'h1010, 16'hA054, 16'hA045, 16'h3050};
	wire  [3:0]  en = {dplus_pullup_enable, dplus_pulldown_enable,
		dminus_pulldown_enable, highspeed_termination_enable};
	usrd_state_decode usrd_state_decode_i (.*);
	usrd_link_model usrd_link_model_i (.*);
	initial forever #5 aclk = ~aclk;
	task chk(input string nm, input [33:0] got, input [33:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task conclude();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		conclude();
	end
	initial begin
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk("reset en", en, 4'h6);
		usrd_link_model_i.rd(8'h00, d, r);
		chk("reset ctrl", d, 32'h0000_0061);
		foreach (rows[i]) begin
			usrd_link_model_i.wr(8'h00, {25'h0, rows[i][6:0]}, 4'h1, r);
			chk("bresp", r, 2'h0);
			chk("enables", en, rows[i][15:12]);
			usrd_link_model_i.rd(8'h04, d, r);
			chk("status", d, {28'h0, rows[i][12], rows[i][13], rows[i][14],
				rows[i][15]});
		end
		// Masked lane and read-only word leave the state alone
		usrd_link_model_i.wr(8'h00, 32'h0000_0068, 4'h0, r);
		chk("masked", {r, en}, {2'h0, 4'h3});
		usrd_link_model_i.wr(8'h04, 32'h0000_0068, 4'h1, r);
		chk("ro write", {r, en}, {2'h2, 4'h3});
		usrd_link_model_i.wr(8'h08, 32'h0000_0068, 4'h1, r);
		chk("unmapped wr", {r, en}, {2'h3, 4'h3});
		usrd_link_model_i.rd(8'h08, d, r);
		chk("unmapped", {r, d}, {2'h3, 32'h0});
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("rerun en", en, 4'h6);
		conclude();
	end
endmodule // test_usrd_state_decode
bind usrd_state_decode usrd_checker usrd_checker_i (.*);

//--- tb/usrd_link_model.sv
`timescale 1ns/1ns
module usrd_link_model (
	// Clock
	input  wire        aclk,
	// Requests
	output reg  [7:0]  s_axi_awaddr,
	output reg         s_axi_awvalid,
	output reg  [31:0] s_axi_wdata,
	output reg  [3:0]  s_axi_wstrb,
	output reg         s_axi_wvalid,
	output reg         s_axi_bready,
	output reg  [7:0]  s_axi_araddr,
	output reg         s_axi_arvalid,
	output reg         s_axi_rready,
	// Answers
	input  wire        s_axi_awready,
	input  wire        s_axi_wready,
	input  wire [1:0]  s_axi_bresp,
	input  wire        s_axi_bvalid,
	input  wire        s_axi_arready,
	input  wire [31:0] s_axi_rdata,
	input  wire [1:0]  s_axi_rresp,
	input  wire        s_axi_rvalid
);
	initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb,
		s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid,
		s_axi_rready} = 57'h0;
	// The link alone picks every bus state it wants
	task wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		fork
			begin
				do @(posedge aclk); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
				// Stale data must not pass for a good word
				s_axi_wdata <= ~d;
			end
		join
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input [7:0] a, output [31:0] d, output [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // usrd_link_model

//--- tb/usrd_state_decode_asserts.sv
`timescale 1ns/1ns
module usrd_checker (
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// Write data and response
	input logic [31:0] s_axi_wdata,
	input logic [3:0]  s_axi_wstrb,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	// Resistor enables
	input logic        dplus_pullup_enable,
	input logic        dplus_pulldown_enable,
	input logic        dminus_pulldown_enable,
	input logic        highspeed_termination_enable
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] wd;
	wire  [3:0] en = {dplus_pullup_enable, dplus_pulldown_enable,
		dminus_pulldown_enable, highspeed_termination_enable};
	// Only an OKAY write with byte lane 0 strobed reaches the control fields
	wire        ok = s_axi_bresp == 2'h0 && wd[7];
	wire  [3:0] ex = wd[4:3] == 2'h1 ? 4'h0 : {wd[2] & ~wd[5], wd[5],
		wd[6], wd[1:0] == 2'h0 && !wd[2]};
	always @(posedge aclk)
		if (s_axi_wvalid && s_axi_wready)
			wd <= {s_axi_wstrb[0], s_axi_wdata[6:0]};
	a_reset_vals: assert property (disable iff (1'b0)
		!aresetn |=> en == 4'h6) else $error("enables not reset");
	a_change_cause: assert property (
		$changed(en) |-> $rose(s_axi_bvalid) && ok) else $error("stray change");
	a_en_hold: assert property (
		$rose(s_axi_bvalid) |=> $stable(en) [*2]) else $error("enables moved");
	a_mode_off: assert property (
		$rose(s_axi_bvalid) && ok && wd[4:3] == 2'h1 |-> en == 4'h0)
		else $error("disabled mode not off");
	a_pullup_dec: assert property (
		$rose(s_axi_bvalid) && ok |-> dplus_pullup_enable == ex[3])
		else $error("pull-up wrong");
	a_pullup_excl: assert property (
		dplus_pullup_enable |-> en[2] == 1'b0 && en[0] == 1'b0)
		else $error("pull-up with conflicting load");
	a_dp_pd: assert property (
		$rose(s_axi_bvalid) && ok |-> en[2] == ex[2]) else $error("dp pd wrong");
	a_dm_pd: assert property (
		$rose(s_axi_bvalid) && ok |-> en[1] == ex[1]) else $error("dm pd wrong");
	a_hs_term: assert property (
		$rose(s_axi_bvalid) && ok |-> en[0] == ex[0]) else $error("hs term wrong");
	a_host_jk: assert property (
		$rose(s_axi_bvalid) && ok && wd[6:0] == 7'h70 |-> en == 4'h7)
		else $error("host test state wrong");
	a_periph_jk: assert property (
		$rose(s_axi_bvalid) && ok && wd[6:0] == 7'h10 |-> en == 4'h1)
		else $error("peripheral test state wrong");
endmodule // usrd_checker
